// >>> logic/mode_map_pkg.sv
// Constants and types for memory map decode and mode selection
package mode_map_pkg;
  // Register indexes; the byte address on the bus is four times the index
  localparam logic [15:0] IDX_PRIORITY_MODE = 16'h103c;
  localparam logic [15:0] IDX_RAM_IO_MAP    = 16'h103d;
  localparam logic [15:0] IDX_RESERVED      = 16'h103e;
  localparam logic [15:0] IDX_STARTUP_OPT   = 16'h103f;
  localparam int          BUS_ADDR_W        = 18;

  // Reset values
  localparam logic [7:0] PRIORITY_MODE_RST = 8'h06;
  localparam logic [7:0] RAM_IO_MAP_RST    = 8'h01;
  localparam logic [7:0] STARTUP_OPT_RST   = 8'h00;
  localparam logic [3:0] IRQ_PSEL_RST      = 4'h6;
  localparam logic [3:0] EE_PAGE_RST       = 4'hf;

  // Priority and mode register fields
  localparam int HP_BOOT = 7;
  localparam int HP_SPECIAL_MODE_BIT = 6;
  localparam int HP_MDA  = 5;
  localparam int HP_IRV  = 4;

  // Startup options fields
  localparam int CF_SECURITY_DISABLE = 3;
  localparam int CF_WATCHDOG_DISABLE = 2;
  localparam int CF_PROGRAM_ROM_ENABLE = 1;
  localparam int CF_EEPROM_ENABLE  = 0;

  // Map geometry
  localparam logic [15:0] BOOT_LO     = 16'hbf00;
  localparam logic [15:0] BOOT_HI     = 16'hbfff;
  localparam logic [15:0] EE512_LO    = 16'hb600;
  localparam logic [15:0] EE512_HI    = 16'hb7ff;
  localparam logic [11:0] EE2K_OFS_LO = 12'h800;
  localparam logic [15:0] VEC_NORMAL  = 16'hfffa;
  localparam logic [15:0] VEC_SPECIAL = 16'hbffa;
  localparam logic [15:0] ROM_LO      = 16'hd000;
  localparam logic [11:0] REGBLK_SIZE = 12'h040;
  localparam logic [11:0] RAM_SIZE    = 12'h200;

  // Protected write window after reset
  localparam logic [6:0] PROTECT_CYCLES = 7'h40;

  typedef enum logic [1:0] {
    MODE_SINGLE,
    MODE_EXPANDED,
    MODE_BOOTSTRAP,
    MODE_TEST
  } mode_t;

  typedef struct packed {
    logic regblk;
    logic ram;
    logic boot_rom;
    logic eeprom;
    logic prog_rom;
    logic external;
  } sel_t;
endpackage : mode_map_pkg

// >>> logic/mode_map_ctrl.sv
// Memory map priority decode, mode latching and protected startup registers
//
// Summary of operation
// - Registers outrank RAM, RAM outranks ROM
// - Overlapped address reaches only the higher resource
// - Boot ROM mapped only in special modes, enabled after bootstrap reset
// - Expanded modes: ROM needs the enable bit
// - Single chip, bootstrap: ROM always enabled
// - Small EEPROM fixed at B600 to B7FF
// - Large EEPROM pages on 4K boundaries
// - EEPROM decoded with ROM access timing
// - Mode bits loaded from sampled mode pins
// - Pin pairs map to four modes
// - Mode pins ignored after reset release
// - Mode A pin marks instruction fetch, open-drain
// - Pin B high: vectors at FFFA
// - Pin B low: vectors at BFFA, test
// - Protected bits: once in 64 cycles normally
// - Mode register resets mode dependent, priority 0110
// - Special bit never sets again; mode A once in normal modes
// - Boot enable writable only in special modes
//
// Decided for this implementation: register access over Avalon-MM.
module mode_map_ctrl #(
  parameter bit EEPROM_2K = 1'b0
) (
  // Clock and reset
  input  wire logic                    i_core_clk,
  input  wire logic                    i_arst_n,
  // Mode pins; pin A doubles as the fetch marker
  input  wire logic                    i_mode_pin_a,
  input  wire logic                    i_mode_pin_b,
  output logic                         o_mode_pin_a_out,
  output logic                         o_mode_pin_a_oe,
  // Nonvolatile startup byte copied at reset
  input  wire logic [7:0]              i_config_nv,
  // CPU side
  input  wire logic [15:0]             i_cpu_addr,
  input  wire logic                    i_instr_first_cycle,
  output mode_map_pkg::sel_t           o_sel,
  output logic [15:0]                  o_vector_addr,
  output logic                         o_test_access,
  output logic [1:0]                   o_mode,
  output logic                         o_ready,
  // Avalon-MM slave
  input  wire logic [mode_map_pkg::BUS_ADDR_W-1:0] i_avs_address,
  input  wire logic                    i_avs_read,
  input  wire logic                    i_avs_write,
  input  wire logic [31:0]             i_avs_writedata,
  input  wire logic [3:0]              i_avs_byteenable,
  output logic [31:0]                  o_avs_readdata,
  output logic                         o_avs_waitrequest
);
  logic [7:0] priority_and_mode_reg_reg;
  logic [7:0] init_reg;
  logic [7:0] config_reg;
  logic       captured_reg;
  logic [6:0] cycle_cnt_reg;
  logic       mda_once_reg;
  logic       irv_once_reg;
  logic       init_once_reg;
  logic       cfg_once_reg;
  logic       pin_b_reg;
  logic       wait_reg;

  mode_map_pkg::mode_t mode;
  mode_map_pkg::mode_t pin_mode;
  logic special;
  logic in_window;
  logic wr_go;
  logic hit_hp;
  logic hit_init;
  logic hit_cfg;
  logic [7:0] wbyte;

  function automatic logic bus_hit(input logic [mode_map_pkg::BUS_ADDR_W-1:0] a,
                                   input logic [15:0] idx);
    bus_hit = (a == {idx, 2'b00});
  endfunction : bus_hit

  function automatic logic in_page(input logic [15:0] a, input logic [3:0] page,
                                   input logic [11:0] size);
    in_page = (a[15:12] == page) && (a[11:0] < size);
  endfunction : in_page

  // Latched bits alone carry the mode after release
  always_comb begin
    case ({priority_and_mode_reg_reg[mode_map_pkg::HP_SPECIAL_MODE_BIT], priority_and_mode_reg_reg[mode_map_pkg::HP_MDA]})
      2'b00:   mode = mode_map_pkg::MODE_SINGLE;
      2'b01:   mode = mode_map_pkg::MODE_EXPANDED;
      2'b10:   mode = mode_map_pkg::MODE_BOOTSTRAP;
      default: mode = mode_map_pkg::MODE_TEST;
    endcase
  end

  always_comb begin
    case ({i_mode_pin_b, i_mode_pin_a})
      2'b10:   pin_mode = mode_map_pkg::MODE_SINGLE;
      2'b11:   pin_mode = mode_map_pkg::MODE_EXPANDED;
      2'b00:   pin_mode = mode_map_pkg::MODE_BOOTSTRAP;
      default: pin_mode = mode_map_pkg::MODE_TEST;
    endcase
  end

  assign special   = priority_and_mode_reg_reg[mode_map_pkg::HP_SPECIAL_MODE_BIT];
  assign in_window = captured_reg && (cycle_cnt_reg < mode_map_pkg::PROTECT_CYCLES);
  assign wr_go     = i_avs_write && !wait_reg && i_avs_byteenable[0];
  assign hit_hp    = bus_hit(i_avs_address, mode_map_pkg::IDX_PRIORITY_MODE);
  assign hit_init  = bus_hit(i_avs_address, mode_map_pkg::IDX_RAM_IO_MAP);
  assign hit_cfg   = bus_hit(i_avs_address, mode_map_pkg::IDX_STARTUP_OPT);
  assign wbyte     = i_avs_writedata[7:0];

  // Pins are caught on the first edge after release, then never again
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      captured_reg <= 1'b0;
      pin_b_reg    <= 1'b1;
    end else if (!captured_reg) begin
      captured_reg <= 1'b1;
      pin_b_reg    <= i_mode_pin_b;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cycle_cnt_reg <= 7'h00;
    end else if (captured_reg && cycle_cnt_reg < mode_map_pkg::PROTECT_CYCLES) begin
      cycle_cnt_reg <= cycle_cnt_reg + 7'h01;
    end
  end

  // Priority and mode register
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      priority_and_mode_reg_reg    <= mode_map_pkg::PRIORITY_MODE_RST;
      mda_once_reg <= 1'b0;
      irv_once_reg <= 1'b0;
    end else if (!captured_reg) begin
      priority_and_mode_reg_reg[mode_map_pkg::HP_BOOT] <= (pin_mode == mode_map_pkg::MODE_BOOTSTRAP);
      priority_and_mode_reg_reg[mode_map_pkg::HP_SPECIAL_MODE_BIT] <= !i_mode_pin_b;
      priority_and_mode_reg_reg[mode_map_pkg::HP_MDA]  <= i_mode_pin_a;
      priority_and_mode_reg_reg[mode_map_pkg::HP_IRV]  <= (pin_mode == mode_map_pkg::MODE_TEST);
      priority_and_mode_reg_reg[3:0]                   <= mode_map_pkg::IRQ_PSEL_RST;
    end else if (wr_go && hit_hp) begin
      priority_and_mode_reg_reg[3:0] <= wbyte[3:0];
      if (special) begin
        priority_and_mode_reg_reg[mode_map_pkg::HP_BOOT] <= wbyte[mode_map_pkg::HP_BOOT];
        priority_and_mode_reg_reg[mode_map_pkg::HP_SPECIAL_MODE_BIT] <= wbyte[mode_map_pkg::HP_SPECIAL_MODE_BIT];
        priority_and_mode_reg_reg[mode_map_pkg::HP_MDA]  <= wbyte[mode_map_pkg::HP_MDA];
      end else if (!mda_once_reg) begin
        priority_and_mode_reg_reg[mode_map_pkg::HP_MDA] <= wbyte[mode_map_pkg::HP_MDA];
        mda_once_reg                    <= 1'b1;
      end
      if (!irv_once_reg) begin
        priority_and_mode_reg_reg[mode_map_pkg::HP_IRV] <= wbyte[mode_map_pkg::HP_IRV];
        irv_once_reg                    <= 1'b1;
      end
    end
  end

  // RAM and register page map
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      init_reg      <= mode_map_pkg::RAM_IO_MAP_RST;
      init_once_reg <= 1'b0;
    end else if (wr_go && hit_init && (special || (in_window && !init_once_reg))) begin
      init_reg      <= wbyte;
      init_once_reg <= 1'b1;
    end
  end

  // Startup options latches, loaded from the nonvolatile byte
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      config_reg   <= mode_map_pkg::STARTUP_OPT_RST;
      cfg_once_reg <= 1'b0;
    end else if (!captured_reg) begin
      config_reg[7:4] <= EEPROM_2K ? i_config_nv[7:4] : 4'h0;
      config_reg[3:0] <= i_config_nv[3:0];
      if (pin_mode == mode_map_pkg::MODE_SINGLE) begin
        config_reg[mode_map_pkg::CF_PROGRAM_ROM_ENABLE] <= 1'b1;
      end
      if (pin_mode == mode_map_pkg::MODE_EXPANDED || pin_mode == mode_map_pkg::MODE_TEST) begin
        config_reg[mode_map_pkg::CF_SECURITY_DISABLE] <= 1'b1;
      end
    end else if (wr_go && hit_cfg && (special || (in_window && !cfg_once_reg))) begin
      config_reg[7:4] <= EEPROM_2K ? wbyte[7:4] : 4'h0;
      config_reg[3:0] <= wbyte[3:0];
      cfg_once_reg    <= 1'b1;
    end
  end

  // Avalon handshake: one wait cycle, then the access completes
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wait_reg       <= 1'b1;
      o_avs_readdata <= 32'h0000_0000;
    end else begin
      wait_reg <= !(wait_reg && (i_avs_read || i_avs_write));
      if (i_avs_read && wait_reg) begin
        if (hit_hp) begin
          o_avs_readdata <= {24'h00_0000, priority_and_mode_reg_reg};
        end else if (hit_init) begin
          o_avs_readdata <= {24'h00_0000, init_reg};
        end else if (hit_cfg) begin
          o_avs_readdata <= {24'h00_0000, config_reg};
        end else begin
          o_avs_readdata <= 32'h0000_0000;
        end
      end
    end
  end

  assign o_avs_waitrequest = wait_reg;

  // Address decode, registered one cycle after the CPU address
  logic [15:0] ee_lo;
  logic [15:0] ee_hi;
  logic        rom_on;
  logic        hit_reg;
  logic        hit_ram;
  logic        hit_boot;
  logic        hit_ee;
  logic        hit_rom;

  assign ee_lo = EEPROM_2K ? {config_reg[7:4], mode_map_pkg::EE2K_OFS_LO}
                           : mode_map_pkg::EE512_LO;
  assign ee_hi = EEPROM_2K ? {config_reg[7:4], 12'hfff} : mode_map_pkg::EE512_HI;
  assign rom_on = (mode == mode_map_pkg::MODE_SINGLE || mode == mode_map_pkg::MODE_BOOTSTRAP)
                || config_reg[mode_map_pkg::CF_PROGRAM_ROM_ENABLE];
  assign hit_reg  = in_page(i_cpu_addr, init_reg[3:0], mode_map_pkg::REGBLK_SIZE);
  assign hit_ram  = in_page(i_cpu_addr, init_reg[7:4], mode_map_pkg::RAM_SIZE);
  assign hit_boot = special && priority_and_mode_reg_reg[mode_map_pkg::HP_BOOT]
                 && i_cpu_addr >= mode_map_pkg::BOOT_LO && i_cpu_addr <= mode_map_pkg::BOOT_HI;
  assign hit_ee   = config_reg[mode_map_pkg::CF_EEPROM_ENABLE] && i_cpu_addr >= ee_lo && i_cpu_addr <= ee_hi;
  assign hit_rom  = rom_on && i_cpu_addr >= mode_map_pkg::ROM_LO;

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_sel <= '0;
    end else begin
      o_sel.regblk   <= hit_reg;
      o_sel.ram      <= !hit_reg && hit_ram;
      o_sel.boot_rom <= !hit_reg && !hit_ram && hit_boot;
      o_sel.eeprom   <= !hit_reg && !hit_ram && !hit_boot && hit_ee;
      o_sel.prog_rom <= !hit_reg && !hit_ram && !hit_boot && !hit_ee && hit_rom;
      o_sel.external <= !(hit_reg || hit_ram || hit_boot || hit_ee || hit_rom);
    end
  end

  // Mode outputs and fetch marker
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_vector_addr    <= mode_map_pkg::VEC_NORMAL;
      o_test_access    <= 1'b0;
      o_mode           <= 2'b00;
      o_ready          <= 1'b0;
      o_mode_pin_a_out <= 1'b0;
      o_mode_pin_a_oe  <= 1'b0;
    end else begin
      o_vector_addr    <= pin_b_reg ? mode_map_pkg::VEC_NORMAL
                                    : mode_map_pkg::VEC_SPECIAL;
      o_test_access    <= captured_reg && !pin_b_reg;
      o_mode           <= mode;
      o_ready          <= captured_reg;
      o_mode_pin_a_out <= 1'b0;
      // Released while the pins are still being sampled
      o_mode_pin_a_oe  <= captured_reg && i_instr_first_cycle;
    end
  end

  // Checks
  property p_vector_follows_pin;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      captured_reg |=> (o_vector_addr == (pin_b_reg ? 16'hfffa : 16'hbffa));
  endproperty
  a_vector_follows_pin: assert property (p_vector_follows_pin) else $error("vector area wrong");

  property p_special_mode_bit_never_sets;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      (captured_reg && !special) |=> !special;
  endproperty
  a_special_mode_bit_never_sets: assert property (p_special_mode_bit_never_sets) else $error("special bit set again");

  property p_boot_only_special;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      o_sel.boot_rom |-> $past(special) && $past(priority_and_mode_reg_reg[7]);
  endproperty
  a_boot_only_special: assert property (p_boot_only_special) else $error("boot rom mapped");

  property p_one_hot_sel;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      captured_reg |-> $onehot(o_sel);
  endproperty
  a_one_hot_sel: assert property (p_one_hot_sel) else $error("select not one hot");

  property p_reg_over_ram;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      (i_arst_n && hit_reg) |=> o_sel.regblk && !o_sel.ram && !o_sel.prog_rom;
  endproperty
  a_reg_over_ram: assert property (p_reg_over_ram) else $error("register block lost");

  property p_rom_forced;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      (i_arst_n && mode == mode_map_pkg::MODE_SINGLE && i_cpu_addr == 16'hfffe && !hit_reg
       && !hit_ram
       && !hit_ee) |=> o_sel.prog_rom;
  endproperty
  a_rom_forced: assert property (p_rom_forced) else $error("rom not enabled");

  property p_init_locked;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      (!special && cycle_cnt_reg == 7'h40) |=> $stable(init_reg);
  endproperty
  a_init_locked: assert property (p_init_locked) else $error("map written late");

  property p_cfg_locked;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      (!special && cycle_cnt_reg == 7'h40) |=> $stable(config_reg);
  endproperty
  a_cfg_locked: assert property (p_cfg_locked) else $error("options written late");

  // Small part only; the paged variant moves the window
  property p_ee_fixed;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      (i_arst_n && !EEPROM_2K && config_reg[mode_map_pkg::CF_EEPROM_ENABLE] && i_cpu_addr >= 16'hb600
       && i_cpu_addr <= 16'hb7ff && !hit_reg && !hit_ram) |=> o_sel.eeprom;
  endproperty
  a_ee_fixed: assert property (p_ee_fixed) else $error("eeprom window missed");

  property p_pins_ignored;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      (captured_reg && !(wr_go && hit_hp)) |=> $stable(priority_and_mode_reg_reg[6:5]);
  endproperty
  a_pins_ignored: assert property (p_pins_ignored) else $error("mode changed by pins");

  property p_fetch_marker;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      (captured_reg && i_instr_first_cycle) |=> o_mode_pin_a_oe && !o_mode_pin_a_out;
  endproperty
  a_fetch_marker: assert property (p_fetch_marker) else $error("fetch marker missing");

  property p_latch_mode;
    @(posedge i_core_clk) disable iff (!i_arst_n)
      // Sampled reset level keeps the attempt at the release edge out
      (i_arst_n && !captured_reg)
        |=> priority_and_mode_reg_reg[6] == !$past(i_mode_pin_b) && priority_and_mode_reg_reg[3:0] == 4'h6;
  endproperty
  a_latch_mode: assert property (p_latch_mode) else $error("mode bits not latched");
endmodule : mode_map_ctrl

// >>> tb/cpu_pins_model.sv
// Model of the CPU core and mode pins facing the mode and map block
module cpu_pins_model (
  // Clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_arst_n,
  // Bench controls
  input  wire logic i_sel_a,
  input  wire logic i_sel_b,
  input  wire logic i_rand,
  // Pin A drive from the block
  input  wire logic i_pin_a_out,
  input  wire logic i_pin_a_oe,
  // Levels seen by the block
  output logic      o_mode_pin_a,
  output logic      o_mode_pin_b,
  output logic      o_instr_first_cycle
);
  timeunit 1ns;
  timeprecision 100ps;
  logic released_reg;

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      released_reg        <= 1'b0;
      o_instr_first_cycle <= 1'b0;
    end else begin
      released_reg        <= 1'b1;
      o_instr_first_cycle <= released_reg & i_rand;
    end
  end

  // Pins swing once captured, so a late sample of them would show
  assign o_mode_pin_a = i_pin_a_oe ? i_pin_a_out : (released_reg ? 1'b1 : i_sel_a);
  assign o_mode_pin_b = released_reg ? ~i_sel_b : i_sel_b;
endmodule : cpu_pins_model

// >>> tb/tb.sv
// Self-checking bench for the map decode and mode selection block
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic               i_core_clk = 1'b0;
  logic               i_arst_n   = 1'b0;
  logic               sel_a      = 1'b0;
  logic               sel_b      = 1'b1;
  logic [7:0]         config_nv  = 8'h00;
  logic [15:0]        cpu_addr   = 16'h0000;
  logic [17:0]        avs_addr   = 18'h00000;
  logic               avs_rd     = 1'b0;
  logic               avs_wr     = 1'b0;
  logic [31:0]        avs_wdata  = 32'h0;
  logic [7:0]         rnd        = 8'h1e;
  logic               arm        = 1'b0;
  logic               arm_d      = 1'b0;
  logic               fc_d       = 1'b0;
  logic               rdy_d      = 1'b0;
  logic               pin_a, pin_b, first_cyc, pin_a_out, pin_a_oe, ready, waitreq, test_acc;
  mode_map_pkg::sel_t sel;
  logic [15:0]        vec;
  logic [1:0]         mode;
  logic [1:0]         m;
  logic [31:0]        rdata;
  int                 error_cnt  = 0;
  int                 checked    = 0;
  logic [31:0]        exp_rd[$];
  mode_map_pkg::sel_t exp_sel[$];
  logic [1:0]         pins[5] = '{2'b10, 2'b11, 2'b00, 2'b01, 2'b11};
  logic [7:0]         nvs[5]  = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h03};
  logic [7:0]         hp[5]   = '{8'h06, 8'h26, 8'hc6, 8'h76, 8'h26};
  logic [7:0]         cf[5]   = '{8'h03, 8'h09, 8'h01, 8'h09, 8'h0b};

  always #2.5 i_core_clk = ~i_core_clk;

  cpu_pins_model partner_u (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_sel_a(sel_a),
    .i_sel_b(sel_b), .i_rand(rnd[0]), .i_pin_a_out(pin_a_out), .i_pin_a_oe(pin_a_oe),
    .o_mode_pin_a(pin_a), .o_mode_pin_b(pin_b), .o_instr_first_cycle(first_cyc));

  mode_map_ctrl #(.EEPROM_2K(1'b0)) dut_u (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
    .i_mode_pin_a(pin_a), .i_mode_pin_b(pin_b), .o_mode_pin_a_out(pin_a_out),
    .o_mode_pin_a_oe(pin_a_oe), .i_config_nv(config_nv), .i_cpu_addr(cpu_addr),
    .i_instr_first_cycle(first_cyc), .o_sel(sel), .o_vector_addr(vec),
    .o_test_access(test_acc), .o_mode(mode), .o_ready(ready), .i_avs_address(avs_addr),
    .i_avs_read(avs_rd), .i_avs_write(avs_wr), .i_avs_writedata(avs_wdata),
    .i_avs_byteenable(4'h1), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq));

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  always @(posedge i_core_clk) rnd <= lfsr(rnd);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Result watcher: takes the oldest note whenever a result shows
  always @(posedge i_core_clk) begin
    arm_d <= arm;
    fc_d  <= first_cyc;
    rdy_d <= ready;
    if (avs_rd && waitreq === 1'b0) begin
      chk(rdata, exp_rd.size() ? exp_rd.pop_front() : 32'hx);
    end
    if (arm_d) begin
      chk({26'h0, sel}, {26'h0, exp_sel.size() ? exp_sel.pop_front() : 6'hx});
    end
    if (ready === 1'b1 && rdy_d === 1'b1) begin
      chk({30'h0, pin_a_out, pin_a_oe}, {31'h0, fc_d});
    end
  end

  task automatic bus(input logic w, input logic [17:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge i_core_clk);
    avs_addr  <= a;
    avs_wdata <= {24'h0, d};
    avs_rd    <= ~w;
    avs_wr    <= w;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (waitreq !== 1'b0);
    chk(32'(n), 32'd2);
    avs_rd <= 1'b0;
    avs_wr <= 1'b0;
  endtask : bus

  task automatic rd(input logic [17:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask : rd

  task automatic wr(input logic [17:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask : wr

  // Two cycles per address so the registered select lines up with its note
  task automatic dec(input logic [15:0] a, input mode_map_pkg::sel_t e);
    @(posedge i_core_clk);
    cpu_addr <= a;
    arm      <= 1'b1;
    exp_sel.push_back(e);
    @(posedge i_core_clk);
    arm      <= 1'b0;
  endtask : dec

  task automatic restart(input logic b, input logic a, input logic [7:0] nv);
    int n;
    n = 0;
    @(posedge i_core_clk);
    i_arst_n  <= 1'b0;
    sel_b     <= b;
    sel_a     <= a;
    config_nv <= nv;
    repeat (10) @(posedge i_core_clk);
    i_arst_n <= 1'b1;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (ready !== 1'b1);
    chk(32'(n), 32'd3);
  endtask : restart

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (20000) @(posedge i_core_clk);
    error_cnt++;
    report_and_stop();
  end

  initial begin
    for (int i = 0; i < 5; i++) begin
      restart(pins[i][1], pins[i][0], nvs[i]);
      m = (i == 4) ? 2'd1 : 2'(i);
      chk({30'h0, mode}, {30'h0, m});
      chk({16'h0, vec}, m[1] ? 32'hbffa : 32'hfffa);
      chk({31'h0, test_acc}, {31'h0, m[1]});
      rd(18'h040f0, {24'h0, hp[i]});
      rd(18'h040f4, 32'h01);
      rd(18'h040fc, {24'h0, cf[i]});
      rd(18'h040f8, 32'h0);
      rd(18'h00000, 32'h0);
      dec(16'hbf00, (m == 2'd2) ? 6'h08 : 6'h01);
      dec(16'hfffe, (!m[0] || nvs[i][1]) ? 6'h02 : 6'h01);
      dec(16'he000, (!m[0] || nvs[i][1]) ? 6'h02 : 6'h01);
      dec(16'hb600, 6'h04);
      dec(16'hb7ff, 6'h04);
      dec(16'hb800, 6'h01);
      dec(16'h103f, 6'h20);
      dec(16'h1040, 6'h01);
      dec(16'h01ff, 6'h10);
      dec({4'h2 + {1'b0, rnd[2:0]}, rnd, 4'h0}, 6'h01);
      $display("mode test %0d done", i);
    end
    // Normal mode: only the first write inside the window lands
    restart(1'b1, 1'b0, 8'h00);
    wr(18'h040f4, 8'h00);
    wr(18'h040f4, 8'h11);
    rd(18'h040f4, 32'h00);
    dec(16'h0010, 6'h20);
    dec(16'h0100, 6'h10);
    restart(1'b1, 1'b1, 8'h02);
    repeat (70) @(posedge i_core_clk);
    wr(18'h040f4, 8'h22);
    rd(18'h040f4, 32'h01);
    $display("normal protect test done");
    // Special mode: writes accepted late and repeatedly
    restart(1'b0, 1'b0, 8'h00);
    repeat (80) @(posedge i_core_clk);
    wr(18'h040f4, 8'h31);
    wr(18'h040f4, 8'hd1);
    rd(18'h040f4, 32'hd1);
    dec(16'hd000, 6'h10);
    dec(16'hd200, 6'h02);
    dec(16'h1000, 6'h20);
    wr(18'h040f0, 8'h46);
    rd(18'h040f0, 32'h46);
    dec(16'hbf00, 6'h01);
    wr(18'h040f0, 8'h06);
    wr(18'h040f0, 8'h46);
    rd(18'h040f0, 32'h06);
    $display("special protect test done");
    repeat (4) @(posedge i_core_clk);
    report_and_stop();
  end
endmodule : tb
